//--- pkg/scu_params.svh
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH

// Clock and the command-busy low time after a command.
`define SCU_CLK_PERIOD_NS 20
`define SCU_BUSY_TIME_NS 2000
`define SCU_BUSY_CYC ((`SCU_BUSY_TIME_NS + `SCU_CLK_PERIOD_NS - 1) / `SCU_CLK_PERIOD_NS)

// Command argument field positions and limits.
`define SCU_GAIN_LSB 0
`define SCU_GAIN_MSB 3
`define SCU_GAIN_BAD_A 4'h1
`define SCU_GAIN_BAD_B 4'h2
`define SCU_VOL_LSB 0
`define SCU_VOL_MSB 6
`define SCU_SILENCE_MIN 8'h04
`define SCU_AMP_EN_LSB 0
`define SCU_AMP_EN_MSB 1
`define SCU_CLASS_D_BIT 2

// Host register offsets.
`define SCU_REG_CMD 8'h00
`define SCU_REG_STAT 8'h04
`define SCU_REG_IRQ 8'h08
`define SCU_REG_MASK 8'h0C
`define SCU_REG_CTRL 8'h10

// Command register field positions.
`define SCU_CMD_CODE_LSB 0
`define SCU_CMD_CHAN_LSB 4
`define SCU_CMD_ARG_LSB 8
`define SCU_CMD_I2C_BIT 16

// Interrupt bits, mask reset value and bus response codes.
`define SCU_IRQ_DONE 0
`define SCU_IRQ_REFUSED 1
`define SCU_IRQ_RETRY 2
`define SCU_MASK_RST 3'h0
`define SCU_RESP_OKAY 2'h0
`define SCU_RESP_SLVERR 2'h2

`endif

//--- pkg/scu_pkg.sv
`include "scu_params.svh"

package scu_pkg;

  // Host command codes.
  typedef enum logic [3:0] {
    SCU_CMD_NOP = 4'h0,
    SCU_CMD_POWER_UP = 4'h1,
    SCU_CMD_POWER_DOWN = 4'h2,
    SCU_CMD_START = 4'h3,
    SCU_CMD_STOP = 4'h4,
    SCU_CMD_MUTE_INSERT = 4'h5,
    SCU_CMD_LOOP_SET = 4'h6,
    SCU_CMD_LOOP_CLEAR = 4'h7,
    SCU_CMD_CHANNEL_VOLUME = 4'h8,
    SCU_CMD_ANALOG_VOLUME = 4'h9,
    SCU_CMD_AMP = 4'hA,
    SCU_CMD_FLASH_DIRECT = 4'hB
  } scu_cmd_t;

  // Host sequencer states.
  typedef enum logic [4:0] {
    SCU_H_IDLE = 5'h01,
    SCU_H_WAIT_RDY = 5'h02,
    SCU_H_SEND = 5'h04,
    SCU_H_WAIT_LOW = 5'h08,
    SCU_H_WAIT_HIGH = 5'h10
  } scu_host_st_t;

  // Device end state.
  typedef struct packed {
    logic powered;
    logic flash_mode;
    logic [3:0] play;
    logic [3:0] loop;
    logic [3:0] mute_chan;
    logic [7:0] silence_len;
    logic [3:0][6:0] vol;
    logic [3:0] gain;
    logic [1:0] amp_en;
    logic class_d;
    logic cmd_rdy;
    logic pb_busy_n;
    logic ign;
  } scu_dev_state_t;

  // Host end state.
  typedef struct packed {
    scu_host_st_t st;
    logic [3:0] code;
    logic [3:0] chan;
    logic [7:0] arg;
    logic via_i2c;
    logic cmd_valid;
    logic powered;
    logic flash_sent;
    logic dev_rst;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scu_host_state_t;

  // Busy timer state.
  typedef struct packed {
    logic [15:0] cnt;
    logic busy_n;
  } scu_timer_state_t;

endpackage

//--- pkg/scu_cmd_if.sv
`timescale 1ns/1ps

interface scu_cmd_if;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [3:0] cmd_chan;
  logic [7:0] cmd_arg;
  logic cmd_via_i2c;
  logic active_low_reset_pin;
  logic command_busy_n;
  logic playback_busy_n;
  logic next_command_ready;

  modport dev (
    input cmd_valid, cmd_code, cmd_chan, cmd_arg, cmd_via_i2c, active_low_reset_pin,
    output command_busy_n, playback_busy_n, next_command_ready
  );

  modport host (
    output cmd_valid, cmd_code, cmd_chan, cmd_arg, cmd_via_i2c, active_low_reset_pin,
    input command_busy_n, playback_busy_n, next_command_ready
  );
endinterface

//--- rtl/scu_busy_timer.sv
`timescale 1ns/1ps
`include "scu_params.svh"

module scu_busy_timer
  import scu_pkg::*;
#(
  parameter int unsigned CYC = `SCU_BUSY_CYC
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Start of a busy period.
  input wire logic load,
  // Low while busy.
  output logic busy_n
);

  scu_timer_state_t st_ff;
  scu_timer_state_t nxt_st;

  // Reload on every accepted command, so a stop during busy stretches it.
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.cnt = 16'(CYC);
    end else if (st_ff.cnt != 16'h0000) begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
    nxt_st.busy_n = (nxt_st.cnt == 16'h0000);
  end

  // Count register.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{cnt: 16'h0000, busy_n: 1'b1};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign busy_n = st_ff.busy_n;

endmodule

//--- rtl/scu_device_end.sv
`timescale 1ns/1ps
`include "scu_params.svh"

module scu_device_end
  import scu_pkg::*;
#(
  parameter int unsigned BUSY_CYC = `SCU_BUSY_CYC
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Command link towards the host.
  scu_cmd_if.dev link,
  // Power and mode.
  output logic powered,
  output logic flash_mode,
  // Per-channel playback state.
  output logic [3:0] chan_play,
  output logic [3:0] chan_loop,
  output logic [3:0] mute_chan,
  output logic [7:0] silence_len,
  output logic [3:0][6:0] chan_vol,
  // Output stage settings.
  output logic [3:0] analog_gain,
  output logic [1:0] amp_en,
  output logic class_d_select,
  // One-cycle pulse when an accepted command had no effect.
  output logic cmd_ignored
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  scu_dev_state_t st_ff;
  scu_dev_state_t nxt_st;
  logic dev_rst;
  logic busy_n;
  logic is_stop;
  logic cmd_take;
  logic chan_ok;
  logic cmd_load;

  // The reset pin is sampled like any synchronous input and acts as a
  // second synchronous reset of the whole end.
  assign dev_rst = srst | ~link.active_low_reset_pin;

  // ****************************************************************
  // Command acceptance
  // ****************************************************************

  // A command is taken while idle; a stop also while playback runs,
  // even when busy, so playback can always be cut short.
  // In flash mode every command is dropped without a busy period.
  assign is_stop = (link.cmd_code == SCU_CMD_STOP);
  assign chan_ok = |link.cmd_chan;
  assign cmd_take = link.cmd_valid & ~st_ff.flash_mode &
    (busy_n | (is_stop & |st_ff.play));
  assign cmd_load = ce & cmd_take;

  // Busy period of every accepted command, ignored ones included,
  // so the host always sees the handshake complete.
  scu_busy_timer #(
    .CYC(BUSY_CYC)
  ) u_busy (
    .clk(clk),
    .srst(dev_rst),
    .ce(ce),
    .load(cmd_load),
    .busy_n(busy_n)
  );

  // ****************************************************************
  // Command execution
  // ****************************************************************

  // Decode and apply one taken command.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ign = 1'b0;
    if (cmd_take) begin
      case (link.cmd_code)
        SCU_CMD_POWER_UP: begin
          nxt_st.powered = 1'b1;
        end
        SCU_CMD_POWER_DOWN: begin
          nxt_st.powered = 1'b0;
          nxt_st.play = 4'h0;
          nxt_st.loop = 4'h0;
        end
        SCU_CMD_START: begin
          if (chan_ok) begin
            nxt_st.play = st_ff.play | link.cmd_chan;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        SCU_CMD_STOP: begin
          if (chan_ok) begin
            nxt_st.play = st_ff.play & ~link.cmd_chan;
            nxt_st.loop = st_ff.loop & ~link.cmd_chan;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        SCU_CMD_MUTE_INSERT: begin
          if (chan_ok) begin
            nxt_st.mute_chan = link.cmd_chan;
            nxt_st.silence_len = link.cmd_arg;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        SCU_CMD_LOOP_SET: begin
          if (chan_ok) begin
            nxt_st.loop = st_ff.loop | link.cmd_chan;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        SCU_CMD_LOOP_CLEAR: begin
          if (chan_ok) begin
            nxt_st.loop = st_ff.loop & ~link.cmd_chan;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        SCU_CMD_CHANNEL_VOLUME: begin
          // Every selected channel takes the same level.
          for (int i = 0; i < 4; i++) begin
            if (link.cmd_chan[i]) begin
              nxt_st.vol[i] = link.cmd_arg[`SCU_VOL_MSB:`SCU_VOL_LSB];
            end
          end
          nxt_st.ign = ~chan_ok;
        end
        SCU_CMD_ANALOG_VOLUME: begin
          // Forbidden gains are the host's duty and are stored as given.
          nxt_st.gain = link.cmd_arg[`SCU_GAIN_MSB:`SCU_GAIN_LSB];
        end
        SCU_CMD_AMP: begin
          nxt_st.amp_en = link.cmd_arg[`SCU_AMP_EN_MSB:`SCU_AMP_EN_LSB];
          nxt_st.class_d = link.cmd_arg[`SCU_CLASS_D_BIT];
        end
        SCU_CMD_FLASH_DIRECT: begin
          // Only the clocked serial port may open flash access.
          if (st_ff.powered & ~link.cmd_via_i2c) begin
            nxt_st.flash_mode = 1'b1;
          end else begin
            nxt_st.ign = 1'b1;
          end
        end
        default: begin
          nxt_st.ign = 1'b1;
        end
      endcase
    end
    // Playback busy follows the channel set; ready drops at once on a
    // taken command and stays low for good in flash mode.
    nxt_st.pb_busy_n = ~|nxt_st.play;
    nxt_st.cmd_rdy = ~cmd_take & ~nxt_st.flash_mode & busy_n;
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Both resets clear everything, including flash mode.
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      st_ff <= '0;
      st_ff.cmd_rdy <= 1'b1;
      st_ff.pb_busy_n <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Link outputs, each straight from a register.
  assign link.command_busy_n = busy_n;
  assign link.playback_busy_n = st_ff.pb_busy_n;
  assign link.next_command_ready = st_ff.cmd_rdy;

  // User side outputs.
  assign powered = st_ff.powered;
  assign flash_mode = st_ff.flash_mode;
  assign chan_play = st_ff.play;
  assign chan_loop = st_ff.loop;
  assign mute_chan = st_ff.mute_chan;
  assign silence_len = st_ff.silence_len;
  assign chan_vol = st_ff.vol;
  assign analog_gain = st_ff.gain;
  assign amp_en = st_ff.amp_en;
  assign class_d_select = st_ff.class_d;
  assign cmd_ignored = st_ff.ign;

endmodule

//--- rtl/scu_host_end.sv
`timescale 1ns/1ps
`include "scu_params.svh"

module scu_host_end
  import scu_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  output logic irq,
  // Command link towards the device.
  scu_cmd_if.host link
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  scu_host_state_t st_ff;
  scu_host_state_t nxt_st;
  logic aw_now;
  logic w_now;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [3:0] rc;
  logic [7:0] ra;
  logic bad;

  assign wa = st_ff.aw_got ? st_ff.awaddr : s_axi_awaddr;
  assign wd = st_ff.w_got ? st_ff.wdata : s_axi_wdata;
  assign ws = st_ff.w_got ? st_ff.wstrb : s_axi_wstrb;
  assign aw_now = st_ff.aw_got | (s_axi_awvalid & st_ff.awready);
  assign w_now = st_ff.w_got | (s_axi_wvalid & st_ff.wready);
  assign rc = wd[`SCU_CMD_CODE_LSB +: 4];
  assign ra = wd[`SCU_CMD_ARG_LSB +: 8];

  // Screen a new command; a refused one never reaches the link.
  assign bad = (st_ff.st != SCU_H_IDLE) | st_ff.dev_rst | st_ff.flash_sent |
    ((rc == SCU_CMD_ANALOG_VOLUME) & ((ra[`SCU_GAIN_MSB:`SCU_GAIN_LSB] == `SCU_GAIN_BAD_A) |
    (ra[`SCU_GAIN_MSB:`SCU_GAIN_LSB] == `SCU_GAIN_BAD_B))) |
    ((rc == SCU_CMD_MUTE_INSERT) & (ra < `SCU_SILENCE_MIN)) |
    ((rc == SCU_CMD_AMP) & ra[`SCU_CLASS_D_BIT] & ra[`SCU_AMP_EN_MSB]) |
    ((rc == SCU_CMD_FLASH_DIRECT) & (~st_ff.powered | wd[`SCU_CMD_I2C_BIT]));

  // ****************************************************************
  // Sequencer and register file
  // ****************************************************************

  always_comb begin
    nxt_st = st_ff;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    // Link handshake: wait ready, send, then see busy fall and rise.
    case (st_ff.st)
      SCU_H_WAIT_RDY: begin
        if (link.command_busy_n) begin
          nxt_st.st = SCU_H_SEND;
        end
      end
      SCU_H_SEND: begin
        nxt_st.st = SCU_H_WAIT_LOW;
        if (st_ff.code == SCU_CMD_POWER_UP) begin
          nxt_st.powered = 1'b1;
        end else if (st_ff.code == SCU_CMD_POWER_DOWN) begin
          nxt_st.powered = 1'b0;
        end else if (st_ff.code == SCU_CMD_FLASH_DIRECT) begin
          nxt_st.flash_sent = 1'b1;
        end
      end
      SCU_H_WAIT_LOW: begin
        if (!link.command_busy_n) begin
          nxt_st.st = SCU_H_WAIT_HIGH;
        end
      end
      SCU_H_WAIT_HIGH: begin
        if (link.command_busy_n) begin
          // After a stop, playback must have ended or the stop goes again.
          if ((st_ff.code == SCU_CMD_STOP) && !link.playback_busy_n) begin
            nxt_st.st = SCU_H_SEND;
            irq_set[`SCU_IRQ_RETRY] = 1'b1;
          end else begin
            nxt_st.st = SCU_H_IDLE;
            irq_set[`SCU_IRQ_DONE] = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.st = SCU_H_IDLE;
      end
    endcase
    // Write channels: address and data are held until both are in.
    if (s_axi_awvalid & st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid & s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (aw_now & w_now & ~st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `SCU_RESP_OKAY;
      if (wa == `SCU_REG_CMD) begin
        if (&ws[2:0]) begin
          if (bad) begin
            irq_set[`SCU_IRQ_REFUSED] = 1'b1;
          end else begin
            nxt_st.code = rc;
            nxt_st.chan = wd[`SCU_CMD_CHAN_LSB +: 4];
            nxt_st.arg = ra;
            nxt_st.via_i2c = wd[`SCU_CMD_I2C_BIT];
            // A stop does not wait for ready.
            nxt_st.st = (rc == SCU_CMD_STOP) ? SCU_H_SEND : SCU_H_WAIT_RDY;
          end
        end
      end else if (wa == `SCU_REG_STAT) begin
        nxt_st.bresp = `SCU_RESP_OKAY;
      end else if (wa == `SCU_REG_IRQ) begin
        irq_clr = ws[0] ? wd[2:0] : 3'h0;
      end else if (wa == `SCU_REG_MASK) begin
        nxt_st.irq_mask = ws[0] ? wd[2:0] : st_ff.irq_mask;
      end else if (wa == `SCU_REG_CTRL) begin
        nxt_st.dev_rst = ws[0] ? wd[0] : st_ff.dev_rst;
      end else begin
        nxt_st.bresp = `SCU_RESP_SLVERR;
      end
    end
    // A device reset forgets power-up and flash mode.
    if (st_ff.dev_rst) begin
      nxt_st.powered = 1'b0;
      nxt_st.flash_sent = 1'b0;
    end
    // Read channels.
    if (st_ff.rvalid & s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid & st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `SCU_RESP_OKAY;
      nxt_st.rdata = 32'h00000000;
      if (s_axi_araddr == `SCU_REG_CMD) begin
        nxt_st.rdata = {15'h0000, st_ff.via_i2c, st_ff.arg, st_ff.chan, st_ff.code};
      end else if (s_axi_araddr == `SCU_REG_STAT) begin
        nxt_st.rdata = {27'h0000000, st_ff.flash_sent, st_ff.powered,
          ~link.playback_busy_n, ~link.command_busy_n, st_ff.st != SCU_H_IDLE};
      end else if (s_axi_araddr == `SCU_REG_IRQ) begin
        nxt_st.rdata = {29'h00000000, st_ff.irq_stat};
      end else if (s_axi_araddr == `SCU_REG_MASK) begin
        nxt_st.rdata = {29'h00000000, st_ff.irq_mask};
      end else if (s_axi_araddr == `SCU_REG_CTRL) begin
        nxt_st.rdata = {31'h00000000, st_ff.dev_rst};
      end else begin
        nxt_st.rresp = `SCU_RESP_SLVERR;
      end
    end
    // A new event beats a clear in the same cycle.
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    nxt_st.cmd_valid = (nxt_st.st == SCU_H_SEND);
    nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
    nxt_st.wready = ~nxt_st.w_got & ~nxt_st.bvalid;
    nxt_st.arready = ~nxt_st.rvalid;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.st <= SCU_H_IDLE;
      st_ff.irq_mask <= `SCU_MASK_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign irq = st_ff.irq;
  assign link.cmd_valid = st_ff.cmd_valid;
  assign link.cmd_code = st_ff.code;
  assign link.cmd_chan = st_ff.chan;
  assign link.cmd_arg = st_ff.arg;
  assign link.cmd_via_i2c = st_ff.via_i2c;
  assign link.active_low_reset_pin = ~st_ff.dev_rst;

endmodule

//--- verification/scu_chk.sv
`timescale 1ns/1ps

module scu_chk
  import scu_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Host towards device.
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_chan,
  input wire logic [7:0] cmd_arg,
  input wire logic cmd_via_i2c,
  input wire logic active_low_reset_pin,
  // Device towards host.
  input wire logic command_busy_n,
  input wire logic playback_busy_n,
  input wire logic next_command_ready
);
  // ****
  // Link checks
  // ****
  // The reset pin clears the device end, so its window is left out too.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !active_low_reset_pin);

  logic take;
  logic [15:0] low_cnt_ff;

  // A command is surely taken when the device shows idle and ready.
  assign take = cmd_valid && command_busy_n && next_command_ready;

  // Counts busy low cycles, so the pulse length is checked without unrolling.
  always_ff @(posedge clk) begin
    if (srst || !active_low_reset_pin || command_busy_n
        || (cmd_valid && cmd_code == SCU_CMD_STOP && !playback_busy_n)) begin
      low_cnt_ff <= 16'h0;
    end else begin
      low_cnt_ff <= low_cnt_ff + 16'h1;
    end
  end

  busy_len_a: assert property ($rose(command_busy_n) && !$past(srst)
    && $past(active_low_reset_pin) |-> low_cnt_ff == BUSY_CYC)
    else $error("busy pulse length wrong");
  busy_max_a: assert property (!command_busy_n |-> low_cnt_ff < BUSY_CYC)
    else $error("busy pulse too long");
  take_busy_a: assert property (take |=> !command_busy_n && !next_command_ready)
    else $error("taken command gave no busy");
  stop_any_a: assert property (cmd_valid && cmd_code == SCU_CMD_STOP
    && !playback_busy_n |=> !command_busy_n) else $error("stop not taken");
  zero_mask_a: assert property (take && cmd_chan == 4'h0
    && cmd_code inside {[4'h3:4'h8]} |=> $stable(playback_busy_n))
    else $error("zero mask changed playback");
  gain_ok_a: assert property (cmd_valid && cmd_code == SCU_CMD_ANALOG_VOLUME
    |-> !(cmd_arg[3:0] inside {4'h1, 4'h2})) else $error("bad gain sent");
  silence_ok_a: assert property (cmd_valid && cmd_code == SCU_CMD_MUTE_INSERT
    |-> cmd_arg >= 8'h04) else $error("short silence sent");
  amp_ok_a: assert property (cmd_valid && cmd_code == SCU_CMD_AMP
    |-> !(cmd_arg[2] && cmd_arg[1])) else $error("bad amp enable sent");
  flash_i2c_a: assert property (cmd_valid && cmd_code == SCU_CMD_FLASH_DIRECT
    |-> !cmd_via_i2c) else $error("flash command sent via i2c");
  pin_reset_a: assert property (disable iff (srst) !active_low_reset_pin
    |=> command_busy_n && next_command_ready && playback_busy_n)
    else $error("pin reset did not clear device");

  // Main scenarios.
  cover property (take && cmd_code == SCU_CMD_STOP);
  cover property (take && cmd_chan == 4'h0);
  cover property ($rose(command_busy_n));
endmodule

//--- verification/speech_command_usage_checker_tb.sv
`timescale 1ns/1ps
`include "scu_params.svh"

module speech_command_usage_checker_tb
  import scu_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, powered, flash_mode, cls_d, ign;
  logic ign_seen = 1'b0;
  logic [1:0] bresp, rresp, amp_en;
  logic [31:0] rdata, d;
  logic [3:0] chan_play, chan_loop, mute_chan, gain;
  logic [7:0] silence_len;
  logic [3:0][6:0] chan_vol;
  logic msk = 1'b0;
  int err_count = 0;
  int n_checks = 0;

  // Clock at 50 MHz.
  always #10 clk = ~clk;

  // Latches any ignored-command pulse.
  always @(posedge clk) if (ign) ign_seen <= 1'b1;

  scu_cmd_if scu_cmd_if_inst();
  scu_host_end scu_host_end_inst(.clk(clk), .srst(srst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .link(scu_cmd_if_inst));
  // Short busy time keeps the run brief; the checker gets the same figure.
  scu_device_end #(.BUSY_CYC(4)) scu_device_end_inst(.clk(clk), .srst(srst), .ce(ce),
    .link(scu_cmd_if_inst), .powered(powered), .flash_mode(flash_mode),
    .chan_play(chan_play), .chan_loop(chan_loop), .mute_chan(mute_chan),
    .silence_len(silence_len), .chan_vol(chan_vol), .analog_gain(gain), .amp_en(amp_en),
    .class_d_select(cls_d), .cmd_ignored(ign));
  scu_chk #(.BUSY_CYC(4)) scu_chk_inst(.clk(clk), .srst(srst),
    .cmd_valid(scu_cmd_if_inst.cmd_valid), .cmd_code(scu_cmd_if_inst.cmd_code),
    .cmd_chan(scu_cmd_if_inst.cmd_chan), .cmd_arg(scu_cmd_if_inst.cmd_arg),
    .cmd_via_i2c(scu_cmd_if_inst.cmd_via_i2c),
    .active_low_reset_pin(scu_cmd_if_inst.active_low_reset_pin),
    .command_busy_n(scu_cmd_if_inst.command_busy_n),
    .playback_busy_n(scu_cmd_if_inst.playback_busy_n),
    .next_command_ready(scu_cmd_if_inst.next_command_ready));

  // ****
  // Bus and check tasks
  // ****
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input string nm);
    err_count++;
    $display("[ERR] %s expected answer seen timeout", nm);
    wrap_up();
  endtask

  // Address and data go up together; each is dropped once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    if (bvalid !== 1'b1) tmo("bvalid");
    chk("bresp", 32'(bresp), 32'(`SCU_RESP_OKAY));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    if (rvalid !== 1'b1) tmo("rvalid");
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Sends one command, waits for the sequencer, then checks status and line.
  task automatic run(input logic [3:0] c, input logic [3:0] ch, input logic [7:0] arg,
                     input logic i2c, input logic [2:0] exp);
    int n;
    logic [1:0] r;
    n = 0;
    wr(`SCU_REG_IRQ, 32'h7);
    wr(`SCU_REG_CMD, {15'h0, i2c, arg, ch, c});
    do begin
      rd(`SCU_REG_STAT, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 40);
    if (n >= 40) tmo("sequencer idle");
    rd(`SCU_REG_IRQ, d, r);
    chk("irq_status", d, 32'(exp));
    chk("irq_line", 32'(irq), 32'(msk && exp != 3'h0));
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    logic [1:0] r;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(`SCU_REG_MASK, d, r);
    chk("mask_reset", d, 32'(`SCU_MASK_RST));
    rd(8'h20, d, r);
    chk("unmapped_resp", 32'(r), 32'(`SCU_RESP_SLVERR));
    wr(`SCU_REG_MASK, 32'h7);
    msk = 1'b1;
    run(SCU_CMD_ANALOG_VOLUME, 4'h1, 8'h01, 1'b0, 3'h2);
    run(SCU_CMD_ANALOG_VOLUME, 4'h1, 8'h02, 1'b0, 3'h2);
    run(SCU_CMD_MUTE_INSERT, 4'h1, 8'h03, 1'b0, 3'h2);
    run(SCU_CMD_AMP, 4'h0, 8'h06, 1'b0, 3'h2);
    run(SCU_CMD_FLASH_DIRECT, 4'h0, 8'h00, 1'b0, 3'h2);
    $display("test refusals done");
    run(SCU_CMD_POWER_UP, 4'h0, 8'h00, 1'b0, 3'h1);
    chk("powered", 32'(powered), 32'h1);
    run(SCU_CMD_ANALOG_VOLUME, 4'h0, 8'h03, 1'b0, 3'h1);
    chk("gain", 32'(gain), 32'h3);
    run(SCU_CMD_MUTE_INSERT, 4'h2, 8'h04, 1'b0, 3'h1);
    chk("silence", {mute_chan, 20'h0, silence_len}, 32'h20000004);
    run(SCU_CMD_AMP, 4'h0, 8'h05, 1'b0, 3'h1);
    chk("amp", 32'({cls_d, amp_en}), 32'h5);
    // Empty-mask channel commands must change nothing.
    for (int c = 3; c <= 8; c++) begin
      run(4'(c), 4'h0, 8'h11, 1'b0, 3'h1);
      chk("zero_mask", {chan_play, chan_loop, 24'(chan_vol != 28'h0)}, 32'h0);
    end
    chk("ign_seen", 32'(ign_seen), 32'h1);
    $display("test zero mask done");
    run(SCU_CMD_START, 4'h5, 8'h00, 1'b0, 3'h1);
    chk("play", 32'(chan_play), 32'h5);
    run(SCU_CMD_LOOP_SET, 4'h5, 8'h00, 1'b0, 3'h1);
    run(SCU_CMD_LOOP_CLEAR, 4'h4, 8'h00, 1'b0, 3'h1);
    chk("loop", 32'(chan_loop), 32'h1);
    run(SCU_CMD_CHANNEL_VOLUME, 4'hA, 8'h33, 1'b0, 3'h1);
    chk("chan_vol", 32'(chan_vol), 32'({7'h33, 7'h00, 7'h33, 7'h00}));
    run(SCU_CMD_STOP, 4'h5, 8'h00, 1'b0, 3'h1);
    rd(`SCU_REG_STAT, d, r);
    chk("stop_play", 32'({d[2], chan_play}), 32'h0);
    $display("test playback done");
    run(SCU_CMD_FLASH_DIRECT, 4'h0, 8'h00, 1'b1, 3'h2);
    chk("flash_i2c", 32'(flash_mode), 32'h0);
    wr(`SCU_REG_MASK, 32'h0);
    msk = 1'b0;
    run(SCU_CMD_ANALOG_VOLUME, 4'h0, 8'h01, 1'b0, 3'h2);
    wr(`SCU_REG_MASK, 32'h7);
    msk = 1'b1;
    run(SCU_CMD_FLASH_DIRECT, 4'h0, 8'h00, 1'b0, 3'h1);
    chk("flash_on", 32'(flash_mode), 32'h1);
    run(SCU_CMD_POWER_DOWN, 4'h0, 8'h00, 1'b0, 3'h2);
    chk("flash_held", 32'({flash_mode, powered}), 32'h3);
    wr(`SCU_REG_CTRL, 32'h1);
    wr(`SCU_REG_CTRL, 32'h0);
    chk("flash_off", 32'({flash_mode, powered}), 32'h0);
    run(SCU_CMD_POWER_UP, 4'h0, 8'h00, 1'b0, 3'h1);
    chk("powered_again", 32'(powered), 32'h1);
    $display("test flash mode done");
    wrap_up();
  end
endmodule
